/* hdl/tclf_pkg.sv */
// Shared constants, carriers and helper functions of the control link framer
package tclf_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [4:0] OVH_SLOT0 = 5'h00;
  localparam logic [4:0] OVH_SLOT1 = 5'h01;
  localparam logic [4:0] PCM_SLOT  = 5'h02;
  localparam logic [4:0] PUMP_SLOT = 5'h03;
  localparam logic [4:0] LAST_IDX  = 5'h1F;
  localparam logic [4:0] CRC_BLK   = 5'h01;
  localparam logic [4:0] CRC_SLOT  = OVH_SLOT1;
  localparam logic [4:0] MSG_BLKS  = 5'h04;
  localparam logic [1:0] LAST_PH   = 2'h3;
  localparam int         IVB_BIT   = 0;

  // ----------------------------------------------------------------
  // Check byte, fill values, status fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CRC_POLY  = 8'h07;
  localparam logic [7:0] CRC_INIT  = 8'h00;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [1:0] SRC_PUMP  = 2'h3;
  localparam int         ERR_CRC   = 0;
  localparam int         ERR_OVR   = 1;
  localparam logic [1:0] ERR_RST   = 2'h0;
  localparam logic [3:0] IVB_RST   = 4'hF;

  typedef struct packed {
    logic [4:0] blk;
    logic [4:0] slot;
  } tclf_pos_s;

  typedef struct packed {
    logic [7:0] data;
    tclf_pos_s  pos;
    logic       crc_bad;
  } tclf_rxw_s;

  typedef struct packed {
    logic [1:0] handler;
    logic [7:0] data;
    logic       parity;
  } tclf_mh_s;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_WAIT = 2'b10
  } tclf_txst_e;

  function automatic logic [7:0] crc8_step(input logic [7:0] c_in, input logic [7:0] b);
    logic [7:0] c;
    logic       fb;
    c = c_in;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      fb = c[7] ^ b[i];
      c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  function automatic logic odd_par(input logic [7:0] b);
    return ~^b;
  endfunction

  function automatic logic is_ovh(input logic [4:0] slot);
    return (slot == OVH_SLOT0) || (slot == OVH_SLOT1);
  endfunction

  function automatic logic [1:0] mh_of(input logic [4:0] slot);
    logic [4:0] d;
    d = slot - PCM_SLOT;
    return 2'(d % 5'd3);
  endfunction

  function automatic tclf_pos_s next_pos(input tclf_pos_s p);
    tclf_pos_s n;
    n = p;
    if (p.slot == LAST_IDX)
    begin
      n.slot = 5'h00;
      n.blk  = p.blk + 5'h01;
    end
    else
      n.slot = p.slot + 5'h01;
    return n;
  endfunction

endpackage

/* hdl/tclf_buf2.sv */
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module tclf_buf2 #(
  parameter int W     = 11,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   cnt_r;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_ptr_r];

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      if (pop)
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* hdl/tclf_framer.sv */
// Control link framer: link-side framing, check byte, stream split and merge
// ----------------------------------------------------------------
// Overview of operation
// - Split link into three handler, four intervention, one pump stream; merge only handler and pump streams
// - Each direction has two data leads and its own sync; one link clock
// - Take received check byte from second overhead byte of block one
// - Compare local check over each frame with value carried in next frame
// - Mismatch sets the bad-check bit in the error status register
// - On mismatch handler data still flows, with good parity generated
// - On mismatch pump data and intervention bits still flow unchanged
// - Transmit check byte over each outgoing frame inserted into next frame
// - Board identifier fills outgoing overhead bytes with odd parity, except the check byte slot (block one, second overhead byte)
// - Four slots routed to handler zero are messaging slots
// - Messaging slots are the PCM slot of the first four blocks
// - All eight messaging bits go to handler zero
// - Returned messaging slot is fetched like any other handler slot
// - Intervention bits come out of the messaging slots
// - Thirty-two slots per frame feed the pump path
// ----------------------------------------------------------------
`timescale 1ns/1ps
module tclf_framer #(
  parameter logic [6:0] BOARD_ID = 7'h2A  // Arbitrary neutral value
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             link_clk,
  input  wire logic [1:0]       rx_data,
  input  wire logic             rx_sync,
  output logic [1:0]            tx_data,
  output logic                  tx_sync,
  output tclf_pkg::tclf_mh_s    mh_rx,
  output logic                  mh_rx_valid,
  input  wire logic             mh_rx_ready,
  output logic [7:0]            pump_rx_data,
  output logic                  pump_rx_valid,
  output logic [3:0]            ivb_out,
  output logic [1:0]            err_status,
  input  wire logic [1:0]       err_clear,
  output logic                  tx_fetch,
  output logic [1:0]            tx_fetch_src,
  input  wire logic [7:0]       tx_fetch_data
);
  import tclf_pkg::*;

  // ----------------------------------------------------------------
  // Link domain reset
  // ----------------------------------------------------------------
  logic lrst_s1_r;
  logic lrst_s2_r;
  wire  lrst_n = lrst_s2_r;

  always_ff @(posedge link_clk)
  begin
    lrst_s1_r <= reset_n;
    lrst_s2_r <= lrst_s1_r;
  end

  // ----------------------------------------------------------------
  // Receive framing, link domain
  // ----------------------------------------------------------------
  logic [5:0] rx_sh_r;
  logic [1:0] rx_ph_r;
  tclf_pos_s  rx_pos_r;
  logic       rx_lock_r;
  logic [7:0] rx_acc_r;
  logic [7:0] rx_prev_r;
  logic       rx_have_r;
  tclf_rxw_s  rx_hold_r;
  logic       rx_tgl_r;

  wire [7:0] rx_byte  = {rx_sh_r, rx_data};
  wire       rx_done  = rx_lock_r && !rx_sync && (rx_ph_r == LAST_PH);
  wire       rx_crc_p = (rx_pos_r.blk == CRC_BLK) && (rx_pos_r.slot == CRC_SLOT);
  wire       rx_last  = (rx_pos_r.blk == LAST_IDX) && (rx_pos_r.slot == LAST_IDX);
  wire       rx_mis   = rx_done && rx_crc_p && rx_have_r && (rx_byte != rx_prev_r);
  wire [7:0] rx_acc_n = crc8_step(rx_acc_r, rx_byte);

  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      rx_sh_r   <= '0;
      rx_ph_r   <= '0;
      rx_pos_r  <= '0;
      rx_lock_r <= 1'b0;
      rx_acc_r  <= CRC_INIT;
      rx_prev_r <= CRC_INIT;
      rx_have_r <= 1'b0;
      rx_hold_r <= '0;
      rx_tgl_r  <= 1'b0;
    end
    else if (rx_sync)
    begin
      rx_sh_r   <= {4'h0, rx_data};  // Frame start realigns the counters
      rx_ph_r   <= 2'h1;
      rx_pos_r  <= '0;
      rx_lock_r <= 1'b1;
    end
    else if (rx_lock_r)
    begin
      rx_sh_r <= {rx_sh_r[3:0], rx_data};
      rx_ph_r <= rx_ph_r + 2'h1;
      if (rx_done)
      begin
        rx_pos_r  <= next_pos(rx_pos_r);
        rx_hold_r <= '{data: rx_byte, pos: rx_pos_r, crc_bad: rx_mis};
        rx_tgl_r  <= ~rx_tgl_r;
        if (rx_last)
        begin
          rx_prev_r <= rx_acc_n;  // Held for next frame's carried value
          rx_acc_r  <= CRC_INIT;
          rx_have_r <= 1'b1;  // No compare until one whole frame seen
        end
        else if (!rx_crc_p)
          rx_acc_r <= rx_acc_n;
      end
    end
  end

  a_first_frame_skip: assert property (@(posedge link_clk) disable iff (!lrst_n)
    rx_done && rx_crc_p && !rx_have_r |=> !rx_hold_r.crc_bad)
    else $error("check compared before a full frame");

  a_mis_on_crc_pos: assert property (@(posedge link_clk) disable iff (!lrst_n)
    rx_mis |=> rx_hold_r.crc_bad && rx_hold_r.pos.blk == CRC_BLK
               && rx_hold_r.pos.slot == CRC_SLOT)
    else $error("mismatch off check slot");

  // ----------------------------------------------------------------
  // Receive crossing and routing, system domain
  // ----------------------------------------------------------------
  logic rxt_s1_r;
  logic rxt_s2_r;
  logic rxt_s3_r;
  wire  rx_evt = rxt_s2_r ^ rxt_s3_r;
  // Held word is stable for four link clocks, longer than the toggle takes
  wire tclf_rxw_s rxw = rx_hold_r;

  wire rx_is_ovh  = is_ovh(rxw.pos.slot);
  wire rx_is_pump = (rxw.pos.slot == PUMP_SLOT);
  wire rx_is_msg  = (rxw.pos.slot == PCM_SLOT) && (rxw.pos.blk < MSG_BLKS);
  wire rx_is_mh   = rx_evt && !rx_is_ovh && !rx_is_pump;

  tclf_mh_s buf_in;
  logic     buf_ready;
  logic [10:0] buf_out;

  assign buf_in = '{handler: mh_of(rxw.pos.slot),  // Messaging lands on zero
                    data:    rxw.data,  // Whole byte forwarded
                    parity:  odd_par(rxw.data)};  // Fresh parity despite a bad

  tclf_buf2 #(
    .W     (11),
    .DEPTH (2)
  ) u_buf (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (rx_is_mh),
    .in_ready  (buf_ready),
    .in_data   (buf_in),
    .out_valid (mh_rx_valid),
    .out_ready (mh_rx_ready),
    .out_data  (buf_out)
  );
  assign mh_rx = tclf_mh_s'(buf_out);

  logic [7:0] pump_r;
  logic       pump_v_r;
  logic [3:0] ivb_r;
  logic [1:0] err_r;
  // Link cannot be paused, so a full buffer can only be reported
  wire        ovr_evt = rx_is_mh && !buf_ready;
  wire [1:0]  err_set = {ovr_evt, rx_evt && rxw.crc_bad};

  always_ff @(posedge clk_sys)
  begin
    rxt_s1_r <= rx_tgl_r;
    rxt_s2_r <= rxt_s1_r;
    rxt_s3_r <= rxt_s2_r;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      pump_r   <= '0;
      pump_v_r <= 1'b0;
      ivb_r    <= IVB_RST;
      err_r    <= ERR_RST;
    end
    else
    begin
      pump_v_r <= rx_evt && rx_is_pump;
      if (rx_evt && rx_is_pump)
        pump_r <= rxw.data;
      if (rx_evt && rx_is_msg)
        ivb_r[rxw.pos.blk[1:0]] <= rxw.data[IVB_BIT];
      err_r <= (err_r & ~err_clear) | err_set;  // Set beats clear
    end
  end

  assign pump_rx_data  = pump_r;
  assign pump_rx_valid = pump_v_r;
  assign ivb_out       = ivb_r;
  assign err_status    = err_r;

  a_crc_err_sets: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rx_evt && rxw.crc_bad |=> err_r[ERR_CRC]) else $error("bad check not latched");

  a_mh_parity_good: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mh_rx_valid |-> (^{mh_rx.data, mh_rx.parity}) == 1'b1) else $error("handler parity even");

  a_err_keeps_flow: assert property (@(posedge clk_sys) disable iff (!reset_n)
    err_r[ERR_CRC] && rx_evt && !rx_is_ovh && !rx_is_pump && buf_ready |=> mh_rx_valid)
    else $error("bad check blocked handler data");

  a_msg_to_mh0: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rx_evt && rx_is_msg |-> rx_is_mh && buf_in.handler == 2'h0 && buf_in.data == rxw.data)
    else $error("messaging byte not sent to handler zero");

  a_pump_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rx_evt && rx_is_pump |=> pump_rx_valid && pump_rx_data == $past(rxw.data) ##1 !pump_rx_valid)
    else $error("pump byte not passed");

  a_ivb_extract: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rx_evt && rx_is_msg |=> ivb_out[$past(rxw.pos.blk[1:0])] == $past(rxw.data[IVB_BIT]))
    else $error("intervention bit not extracted");

  // ----------------------------------------------------------------
  // Transmit fetch, system domain
  // ----------------------------------------------------------------
  logic       rqt_s1_r;
  logic       rqt_s2_r;
  logic       rqt_s3_r;
  logic       tx_req_tgl_r;
  wire        rq_evt = rqt_s2_r ^ rqt_s3_r;
  tclf_pos_s  tx_req_pos_r;
  tclf_txst_e tx_st_r;
  logic       fetch_r;
  logic [1:0] fetch_src_r;
  logic [7:0] resp_r;
  logic       resp_tgl_r;
  wire  [7:0] id_byte = {odd_par({1'b0, BOARD_ID}), BOARD_ID};

  always_ff @(posedge clk_sys)
  begin
    rqt_s1_r <= tx_req_tgl_r;
    rqt_s2_r <= rqt_s1_r;
    rqt_s3_r <= rqt_s2_r;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      tx_st_r     <= TX_IDLE;
      fetch_r     <= 1'b0;
      fetch_src_r <= '0;
      resp_r      <= IDLE_BYTE;
      resp_tgl_r  <= 1'b0;
    end
    else
    begin
      unique case (tx_st_r)
        TX_IDLE:
        begin
          if (rq_evt && is_ovh(tx_req_pos_r.slot))
          begin
            resp_r     <= id_byte;  // Overhead carries the board identifier
            resp_tgl_r <= ~resp_tgl_r;
          end
          else if (rq_evt)
          begin
            fetch_r     <= 1'b1;
            fetch_src_r <= (tx_req_pos_r.slot == PUMP_SLOT) ? SRC_PUMP
                                                            : mh_of(tx_req_pos_r.slot);
            tx_st_r     <= TX_WAIT;
          end
        end
        TX_WAIT:
        begin
          fetch_r    <= 1'b0;
          resp_r     <= tx_fetch_data;
          resp_tgl_r <= ~resp_tgl_r;
          tx_st_r    <= TX_IDLE;
        end
      endcase
    end
  end

  assign tx_fetch     = fetch_r;
  assign tx_fetch_src = fetch_src_r;

  a_fetch_answer: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(fetch_r) |=> !fetch_r && resp_r == $past(tx_fetch_data) && $changed(resp_tgl_r))
    else $error("fetched byte not returned");

  // ----------------------------------------------------------------
  // Transmit framing, link domain
  // ----------------------------------------------------------------
  logic       rst_s1_r;
  logic       rst_s2_r;
  logic       rst_s3_r;
  wire        rs_evt = rst_s2_r ^ rst_s3_r;
  logic [1:0] tx_ph_r;
  tclf_pos_s  tx_pos_r;
  logic [7:0] tx_sh_r;
  logic [7:0] tx_pend_r;
  logic [7:0] tx_acc_r;
  logic [7:0] tx_prev_r;
  logic [1:0] tx_data_r;
  logic       tx_sync_r;

  wire       tx_load  = (tx_ph_r == 2'h0);
  wire       tx_crc_p = (tx_pos_r.blk == CRC_BLK) && (tx_pos_r.slot == CRC_SLOT);
  wire       tx_last  = (tx_pos_r.blk == LAST_IDX) && (tx_pos_r.slot == LAST_IDX);
  // Byte taken from the system two bytes ahead to cover the crossing delay
  wire [7:0] tx_lbyte = tx_crc_p ? tx_prev_r : tx_pend_r;
  wire [7:0] tx_cur   = tx_load ? tx_lbyte : tx_sh_r;
  wire [7:0] tx_acc_n = crc8_step(tx_acc_r, tx_lbyte);

  always_ff @(posedge link_clk)
  begin
    rst_s1_r <= resp_tgl_r;
    rst_s2_r <= rst_s1_r;
    rst_s3_r <= rst_s2_r;
  end

  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      tx_ph_r      <= '0;
      tx_pos_r     <= '0;
      tx_sh_r      <= IDLE_BYTE;
      tx_pend_r    <= IDLE_BYTE;
      tx_acc_r     <= CRC_INIT;
      tx_prev_r    <= CRC_INIT;
      tx_req_tgl_r <= 1'b0;
      tx_req_pos_r <= '0;
      tx_data_r    <= 2'h3;
      tx_sync_r    <= 1'b0;
    end
    else
    begin
      tx_ph_r   <= tx_ph_r + 2'h1;
      tx_sh_r   <= {tx_cur[5:0], 2'h0};
      tx_data_r <= tx_cur[7:6];
      tx_sync_r <= tx_load && (tx_pos_r == '0);
      if (rs_evt)
        tx_pend_r <= resp_r;
      if (tx_ph_r == LAST_PH)
        tx_pos_r <= next_pos(tx_pos_r);
      if (tx_load)
      begin
        tx_req_pos_r <= next_pos(next_pos(tx_pos_r));
        tx_req_tgl_r <= ~tx_req_tgl_r;
        if (tx_last)
        begin
          tx_prev_r <= tx_acc_n;  // Sent in the following frame
          tx_acc_r  <= CRC_INIT;
        end
        else if (!tx_crc_p)
          tx_acc_r <= tx_acc_n;
      end
    end
  end

  assign tx_data = tx_data_r;
  assign tx_sync = tx_sync_r;

  a_tx_crc_insert: assert property (@(posedge link_clk) disable iff (!lrst_n)
    tx_load && tx_crc_p |=> tx_data_r == tx_prev_r[7:6] ##1 tx_data_r == tx_prev_r[5:4])
    else $error("check byte not inserted");

  a_tx_sync_frame: assert property (@(posedge link_clk) disable iff (!lrst_n)
    tx_sync_r |-> tx_pos_r == '0 ##4 !tx_sync_r && tx_pos_r.slot == 5'h01)
    else $error("sync not once per frame start");

endmodule

/* tb/tclf_switch_model.sv */
// Behavioural far end of the control link: frame source and transmit checker
`timescale 1ns/1ps
module tclf_switch_model #(
  parameter logic [6:0] BOARD_ID = 7'h2A  // Arbitrary neutral value
) (
  input  wire logic        link_clk,
  input  wire logic        reset_n,
  input  wire logic        corrupt,
  output logic [1:0]       rx_data,
  output logic             rx_sync,
  input  wire logic [1:0]  tx_data,
  input  wire logic        tx_sync,
  output logic [15:0]      frame,
  output logic [15:0]      tx_ok,
  output logic [15:0]      tx_bad
);
  logic [11:0] pos, tpos;
  logic [3:0]  wait_cnt;
  logic [7:0]  acc, prev, tacc, tprev;
  logic [5:0]  tsh;
  logic [15:0] tframe;
  logic        tv;

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction

  // Byte encodes its slot, so a dropped or misrouted byte shows
  function automatic logic [7:0] byte_at(input logic [15:0] f, input logic [11:0] p);
    return {p[6:2], p[9:7] ^ {2'h0, f[0]}};
  endfunction

  // ----------------------------------------------------------------
  // Receive frames, check byte of the previous frame in block 1 slot 1
  // ----------------------------------------------------------------
  wire logic       crc_pos = (pos[11:2] == 10'h021);
  wire logic [7:0] cur     = crc_pos ? (prev ^ {8{corrupt | (frame == 16'h0)}})
                                     : byte_at(frame, pos);

  always @(posedge link_clk)
  begin
    if (!reset_n)
    begin
      wait_cnt <= 4'h0;
      pos      <= 12'h000;
      frame    <= 16'h0;
      acc      <= 8'h00;
      prev     <= 8'h00;
      rx_sync  <= 1'b0;
      rx_data  <= 2'h3;
    end
    else if (wait_cnt != 4'hF)
      wait_cnt <= wait_cnt + 4'h1;
    else
    begin
      rx_sync <= (pos == 12'h000);
      rx_data <= 2'(cur >> (3'd6 - {pos[1:0], 1'b0}));
      if (pos[1:0] == 2'h3 && !crc_pos)
        acc <= crc8(acc, cur);
      if (pos == 12'hFFF)
      begin
        prev  <= crc8(acc, cur);
        acc   <= 8'h00;
        frame <= frame + 16'h1;
      end
      pos <= pos + 12'h1;
    end
  end

  // ----------------------------------------------------------------
  // Transmit checker: board id, lagged check byte, merged sources
  // ----------------------------------------------------------------
  wire logic [11:0] tp   = tx_sync ? 12'h000 : tpos;
  wire logic [7:0]  tb   = {tsh, tx_data};
  wire logic [4:0]  ts   = tp[6:2];
  wire logic        tcrc = (tp[11:2] == 10'h021);
  wire logic [1:0]  tsrc = (ts == 5'h03) ? 2'h3 : 2'((ts - 5'h02) % 5'h03);
  wire logic [7:0]  texp = (ts == 5'h00) ? {~^BOARD_ID, BOARD_ID} : tcrc ? tprev
                                         : {6'h3F, tsrc};
  wire logic        tgood = (ts == 5'h01 && !tcrc) ? ^tb : (tb == texp);

  always @(posedge link_clk)
  begin
    if (!reset_n)
    begin
      tv     <= 1'b0;
      tpos   <= 12'h000;
      tsh    <= 6'h00;
      tframe <= 16'h0;
      tacc   <= 8'h00;
      tprev  <= 8'h00;
      tx_ok  <= 16'h0;
      tx_bad <= 16'h0;
    end
    else if (tv | tx_sync)
    begin
      tv   <= 1'b1;
      tsh  <= {tsh[3:0], tx_data};
      tpos <= tp + 12'h1;
      if (tp[1:0] == 2'h3)
      begin
        if (!tcrc)
          tacc <= crc8(tacc, tb);
        if (tframe != 16'h0 && tgood)
          tx_ok <= tx_ok + 16'h1;
        else if (tframe != 16'h0)
          tx_bad <= tx_bad + 16'h1;
      end
      if (tp == 12'hFFF)
      begin
        tprev  <= crc8(tacc, tb);
        tacc   <= 8'h00;
        tframe <= tframe + 16'h1;
      end
    end
  end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the control link framer
`timescale 1ns/1ps
module testbench;
  import tclf_pkg::*;
  logic        clk_sys, link_clk, reset_n, rx_sync, tx_sync, corrupt;
  logic [1:0]  rx_data, tx_data, err_status, err_clear, tx_fetch_src;
  tclf_mh_s    mh_rx;
  logic        mh_rx_valid, mh_rx_ready, pump_rx_valid, tx_fetch;
  logic [7:0]  pump_rx_data, tx_fetch_data;
  logic [3:0]  ivb_out;
  logic [15:0] frame, tx_ok, tx_bad;
  int          fail_count = 0;
  int          checked = 0;
  int          mh_cnt = 0;
  int          pump_cnt = 0;

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  // Handler returns spare bits high; answer must be valid in the fetch cycle
  assign tx_fetch_data = {6'h3F, tx_fetch_src};

  tclf_framer #(.BOARD_ID(7'h2A)) tclf_framer_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .link_clk(link_clk), .rx_data(rx_data),
    .rx_sync(rx_sync), .tx_data(tx_data), .tx_sync(tx_sync), .mh_rx(mh_rx),
    .mh_rx_valid(mh_rx_valid), .mh_rx_ready(mh_rx_ready), .pump_rx_data(pump_rx_data),
    .pump_rx_valid(pump_rx_valid), .ivb_out(ivb_out), .err_status(err_status),
    .err_clear(err_clear), .tx_fetch(tx_fetch), .tx_fetch_src(tx_fetch_src),
    .tx_fetch_data(tx_fetch_data));

  tclf_switch_model #(.BOARD_ID(7'h2A)) tclf_switch_model_i (
    .link_clk(link_clk), .reset_n(reset_n), .corrupt(corrupt), .rx_data(rx_data),
    .rx_sync(rx_sync), .tx_data(tx_data), .tx_sync(tx_sync), .frame(frame),
    .tx_ok(tx_ok), .tx_bad(tx_bad));

  // ----------------------------------------------------------------
  // Compare, verdict, bounded waits
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("Counts: %0d compared, %0d mismatched", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wait_frame(input logic [15:0] n);
    int k;
    k = 0;
    while (frame !== n && k < 14000)
    begin
      @(posedge clk_sys);
      k++;
    end
    if (frame !== n)
    begin
      fail_count++;
      test_done();
    end
  endtask

  // Every delivered byte is checked against the slot it encodes
  always @(posedge clk_sys)
  begin
    if (reset_n && mh_rx_valid && mh_rx_ready)
    begin
      mh_cnt++;
      chk("mh handler", 16'((mh_rx.data[7:3] - 5'h02) % 5'h03),
          16'(mh_rx.handler));
      chk("mh parity", 16'h1, 16'(^{mh_rx.data, mh_rx.parity}));
      chk("mh slot", 16'h1, 16'(mh_rx.data[7:3] > 5'h03 || mh_rx.data[7:3] == 5'h02));
    end
    if (reset_n && pump_rx_valid)
    begin
      pump_cnt++;
      chk("pump slot", 16'h3, 16'(pump_rx_data[7:3]));
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_state;
    chk("mh valid", 16'h0, 16'(mh_rx_valid));
    chk("pump valid", 16'h0, 16'(pump_rx_valid));
    chk("ivb", 16'hF, 16'(ivb_out));
    chk("err", 16'h0, 16'(err_status));
    chk("tx pair", 16'h3, 16'(tx_data));
    chk("tx sync", 16'h0, 16'(tx_sync));
    chk("fetch", 16'h0, 16'(tx_fetch));
  endtask

  task automatic t_frame_counts(input logic [15:0] n, input logic [3:0] ivb);
    int p0;
    int m0;
    p0 = pump_cnt;
    m0 = mh_cnt;
    wait_frame(n);
    chk("pump per frame", 16'd32, 16'(pump_cnt - p0));
    chk("mh per frame", 16'd928, 16'(mh_cnt - m0));
    chk("ivb", 16'(ivb), 16'(ivb_out));
  endtask

  task automatic t_good_frames;
    wait_frame(16'h2);
    t_frame_counts(16'h3, 4'hA);
    chk("err good", 16'h0, 16'(err_status));
  endtask

  task automatic t_bad_check;
    wait_frame(16'h4);
    chk("ivb odd frame", 16'h5, 16'(ivb_out));
    corrupt <= 1'b1;
    t_frame_counts(16'h5, 4'hA);
    corrupt <= 1'b0;
    chk("bad check flag", 16'h1, 16'(err_status));
  endtask

  task automatic clear_err(input logic [1:0] bits);
    err_clear <= bits;
    @(posedge clk_sys);
    err_clear <= 2'h0;
    repeat (2) @(posedge clk_sys);
    chk("err cleared", 16'h0, 16'(err_status));
  endtask

  task automatic t_clear;
    clear_err(2'h1);
    wait_frame(16'h6);
    chk("err stays clear", 16'h0, 16'(err_status));
  endtask

  task automatic t_stall;
    int k;
    mh_rx_ready <= 1'b0;
    k = 0;
    @(posedge clk_sys);
    while (mh_rx_valid !== 1'b1 && k < 40)
    begin
      @(posedge clk_sys);
      k++;
    end
    repeat (4) @(posedge clk_sys);
    chk("valid held", 16'h1, 16'(mh_rx_valid));
    chk("no overrun", 16'h0, 16'(err_status));
    repeat (200) @(posedge clk_sys);
    chk("overrun flag", 16'h2, 16'(err_status));
    mh_rx_ready <= 1'b1;
    k = 0;
    @(posedge clk_sys);
    while (mh_rx_valid !== 1'b0 && k < 20)
    begin
      @(posedge clk_sys);
      k++;
    end
    chk("drained", 16'h0, 16'(mh_rx_valid));
    clear_err(2'h2);
  endtask

  task automatic t_tx_frames;
    wait_frame(16'h7);
    chk("tx bytes wrong", 16'h0, tx_bad);
    chk("tx bytes seen", 16'h1, 16'(tx_ok != 16'h0));
  endtask

  initial
  begin
    reset_n = 1'b0;
    mh_rx_ready = 1'b1;
    err_clear = 2'h0;
    corrupt = 1'b0;
    repeat (7) @(posedge clk_sys);
    t_reset_state();
    @(posedge clk_sys);
    reset_n <= 1'b1;
    t_good_frames();
    t_bad_check();
    t_clear();
    t_stall();
    t_tx_frames();
    test_done();
  end
endmodule
